// [pkg/shp_cfg.svh]
// ============================================================
// Constants for the stream packet sink: widths, register map, resets.
// Assumes inclusion by shp_pkg, the sink, the source model and the bench; holds definitions and nothing else.
// Functional notes
// - Each end keeps the protocol; the sink does not flag sender faults.
// - Ready asserted in cycle n makes cycle n plus latency a ready cycle.
// - Valid marks each transfer; sink samples all sender signals then.
// - Data is several symbols per beat, each symbol_width_bits wide.
// - Each error bit is one condition; all-zero means clean data.
// - Channel bus comes with a declared highest_channel_number.
// - Symbol zero sits in the most significant bits of data.
// - Without backpressure the sink captures every valid beat.
// - At zero latency a transfer needs ready and valid together.
// - Backpressure exists exactly when ready and a latency are present.
// - Both ends carry start, end and empty signals for packets.
// - Start marker flags first beat; ignored while valid is low.
// - End marker flags last beat; ignored while valid is low.
// - Start and end may share a beat; packets may abut.
// - Empty count is read only on active beats with end marker.
// - Empty symbols are the last ones, the low-order bits.
// - Empty width is log2 of symbols per beat.
// - ready_delay_cycles ranges from zero through eight.
`ifndef SHP_CFG_SVH
`define SHP_CFG_SVH
// ============================================================
// Stream geometry
`define SHP_SYMBOL_W 8
`define SHP_SYMBOLS 4
`define SHP_DATA_W 32
`define SHP_EMPTY_W 2
`define SHP_CHANNEL_W 8
`define SHP_HIGHEST_CHANNEL 8'hFF
`define SHP_ERROR_W 2
`define SHP_LAT_MAX 4'h8
`define SHP_LEN_W 16
// ============================================================
// Register map, byte addresses on the register bus
`define SHP_ADDR_W 5
`define SHP_OFS_CTRL 5'h00
`define SHP_OFS_STATUS 5'h04
`define SHP_OFS_PKT_COUNT 5'h08
`define SHP_OFS_LAST_LEN 5'h0C
`define SHP_OFS_LAST_INFO 5'h10
`define SHP_OFS_LAST_DATA 5'h14
`define SHP_OFS_ERR_COUNT 5'h18
// ============================================================
// Control fields and reset values
`define SHP_CTRL_READY_BIT 0
`define SHP_CTRL_BP_BIT 1
`define SHP_CTRL_LAT_LSB 4
`define SHP_CTRL_CLEAR_BIT 8
`define SHP_RST_READY 1'b1
`define SHP_RST_BP 1'b1
`define SHP_RST_LAT 4'h0
`endif

// [pkg/shp_pkg.sv]
// ============================================================
// Types shared by the stream packet sink.
// Assumes shp_cfg.svh on the include path.
`include "shp_cfg.svh"
package shp_pkg;
  // One beat as the sender presents it
  typedef struct packed {
    logic [`SHP_DATA_W-1:0] data;
    logic [`SHP_CHANNEL_W-1:0] channel;
    logic [`SHP_ERROR_W-1:0] error;
    logic sop;
    logic eop;
    logic [`SHP_EMPTY_W-1:0] empty;
  } shp_beat_type;

  // Packet tracking, Gray order along idle to inside
  typedef enum logic [0:0] {
    SHP_IDLE = 1'b0,
    SHP_IN_PACKET = 1'b1
  } shp_phase_type;

  // All state of the sink in one word
  typedef struct packed {
    logic ctrlReady;
    logic ctrlBp;
    logic [3:0] ctrlLat;
    logic [8:1] readyHist;
    shp_phase_type phase;
    logic [`SHP_LEN_W-1:0] curLen;
    logic [31:0] pktCount;
    logic [31:0] errCount;
    logic [`SHP_LEN_W-1:0] lastLen;
    logic [`SHP_CHANNEL_W-1:0] lastChannel;
    logic [`SHP_ERROR_W-1:0] lastError;
    logic [`SHP_DATA_W-1:0] lastData;
    logic ackPending;
    logic [31:0] readData;
  } shp_state_type;
endpackage

// [core/shp_sink.sv]
// ============================================================
// Stream packet sink: takes beats with packet markers, counts packets
// and symbols, and shows the results on a memory-mapped register bus.
// Assumes one clock, a sender that keeps its side of the protocol and
// a bus master that holds each request until waitrequest is low.
`timescale 1ns/1ps
`include "shp_cfg.svh"
module shp_sink
  import shp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [`SHP_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Stream side
  input wire logic inValid,
  input wire shp_beat_type inBeat,
  output logic outReady
);

  // ============================================================
  // State register and derived signals
  localparam shp_state_type SHP_STATE_RESET = '{
    ctrlReady: `SHP_RST_READY,
    ctrlBp: `SHP_RST_BP,
    ctrlLat: `SHP_RST_LAT,
    phase: SHP_IDLE,
    default: '0
  };

  shp_state_type st_reg;
  shp_state_type st_next;
  logic [3:0] latEff;
  logic readyCycle;
  logic take;
  logic [`SHP_SYMBOL_W-1:0] symbols [0:`SHP_SYMBOLS-1];
  logic [`SHP_DATA_W-1:0] keptData;
  logic [`SHP_LEN_W-1:0] beatSyms;
  logic [`SHP_LEN_W-1:0] pktLen;
  logic busWrite;
  logic clearCounts;
  logic [31:0] readMux;

  // Latency above eight is clamped so the history never overruns
  assign latEff = (st_reg.ctrlLat > `SHP_LAT_MAX) ? `SHP_LAT_MAX :
                  st_reg.ctrlLat;

  // Ready comes straight from a control flop; the sink never stalls
  // internally since each beat only updates counters
  assign outReady = st_reg.ctrlReady;

  // Ready cycle is ready delayed by the latency; zero means same cycle
  assign readyCycle = (latEff == 4'h0) ? outReady :
                      st_reg.readyHist[latEff];

  // Backpressure gating only when the mode is on; valid qualifies all
  // sampling, and nothing counts while reset holds
  assign take = rst_n && inValid &&
                (!st_reg.ctrlBp || readyCycle);

  // ============================================================
  // Symbol split: symbol 0 is the most significant slice
  genvar gi;
  generate
    for (gi = 0; gi < `SHP_SYMBOLS; gi = gi + 1) begin : g_sym
      assign symbols[gi] =
        inBeat.data[`SHP_DATA_W-1-gi*`SHP_SYMBOL_W -: `SHP_SYMBOL_W];
      // Empty symbols are the trailing, low-order ones; zero them
      assign keptData[`SHP_DATA_W-1-gi*`SHP_SYMBOL_W -: `SHP_SYMBOL_W] =
        (inBeat.eop && (gi >= `SHP_SYMBOLS - inBeat.empty)) ?
        {`SHP_SYMBOL_W{1'b0}} : symbols[gi];
    end
  endgenerate

  // Symbols in this beat: empty counts only on end beats
  assign beatSyms = inBeat.eop ?
    `SHP_LEN_W'(`SHP_SYMBOLS) - `SHP_LEN_W'(inBeat.empty) :
    `SHP_LEN_W'(`SHP_SYMBOLS);

  // A start beat restarts the length even mid-packet, as sender rules
  // forbid that case and no fault is flagged for it
  assign pktLen = (inBeat.sop ? `SHP_LEN_W'(0) : st_reg.curLen) +
                  beatSyms;

  // ============================================================
  // Bus decode: one wait cycle, then the answer
  assign waitrequest = (read || write) && !st_reg.ackPending;
  assign busWrite = write && st_reg.ackPending;
  assign clearCounts = busWrite &&
                       (address[4:2] == 3'(`SHP_OFS_CTRL >> 2)) &&
                       byteenable[1] && writedata[`SHP_CTRL_CLEAR_BIT];
  assign readdata = st_reg.readData;

  // Read mux; unmapped addresses answer zero
  always_comb begin
    readMux = 32'h0000_0000;
    case (address[4:2])
      3'(`SHP_OFS_CTRL >> 2): begin
        readMux[`SHP_CTRL_READY_BIT] = st_reg.ctrlReady;
        readMux[`SHP_CTRL_BP_BIT] = st_reg.ctrlBp;
        readMux[`SHP_CTRL_LAT_LSB +: 4] = st_reg.ctrlLat;
      end
      3'(`SHP_OFS_STATUS >> 2): begin
        readMux[0] = (st_reg.phase == SHP_IN_PACKET);
        readMux[1] = readyCycle;
      end
      3'(`SHP_OFS_PKT_COUNT >> 2): begin
        readMux = st_reg.pktCount;
      end
      3'(`SHP_OFS_LAST_LEN >> 2): begin
        readMux[`SHP_LEN_W-1:0] = st_reg.lastLen;
      end
      3'(`SHP_OFS_LAST_INFO >> 2): begin
        readMux[`SHP_CHANNEL_W-1:0] = st_reg.lastChannel;
        readMux[8 +: `SHP_ERROR_W] = st_reg.lastError;
      end
      3'(`SHP_OFS_LAST_DATA >> 2): begin
        readMux = st_reg.lastData;
      end
      3'(`SHP_OFS_ERR_COUNT >> 2): begin
        readMux = st_reg.errCount;
      end
      default: begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  // ============================================================
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.readyHist = {st_reg.readyHist[7:1], outReady};
    // Bus handshake: the ack flop holds for one cycle per request
    st_next.ackPending = (read || write) && !st_reg.ackPending;
    if ((read || write) && !st_reg.ackPending) begin
      st_next.readData = readMux;
    end
    // Control writes take effect on the answering edge
    if (busWrite && (address[4:2] == 3'(`SHP_OFS_CTRL >> 2))) begin
      if (byteenable[0]) begin
        st_next.ctrlReady = writedata[`SHP_CTRL_READY_BIT];
        st_next.ctrlBp = writedata[`SHP_CTRL_BP_BIT];
        st_next.ctrlLat = writedata[`SHP_CTRL_LAT_LSB +: 4];
      end
    end
    // Counters: a clear in the same cycle as an event leaves a count
    // of one, so no event is lost
    if (clearCounts) begin
      st_next.pktCount = 32'h0000_0000;
      st_next.errCount = 32'h0000_0000;
    end
    if (take) begin
      st_next.lastChannel = inBeat.channel;
      st_next.lastData = keptData;
      st_next.curLen = pktLen;
      // Nonzero error on any bit marks the beat as faulty
      if (inBeat.error != `SHP_ERROR_W'(0)) begin
        st_next.errCount = (clearCounts ? 32'h0000_0000 :
                            st_reg.errCount) + 32'h0000_0001;
      end
      st_next.lastError = inBeat.error;
      case (st_reg.phase)
        SHP_IDLE: begin
          if (inBeat.sop && !inBeat.eop) begin
            st_next.phase = SHP_IN_PACKET;
          end
        end
        SHP_IN_PACKET: begin
          if (inBeat.eop && !inBeat.sop) begin
            st_next.phase = SHP_IDLE;
          end
        end
        default: begin
          st_next.phase = SHP_IDLE;
        end
      endcase
      // Abutting packets: an end beat followed directly by a start
      if (inBeat.eop) begin
        st_next.phase = SHP_IDLE;
        st_next.lastLen = pktLen;
        st_next.pktCount = (clearCounts ? 32'h0000_0000 :
                            st_reg.pktCount) + 32'h0000_0001;
      end
    end
  end

  // Synchronous reset; state flops load the constant
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= SHP_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ============================================================
  // Checks on the sink's own behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Ready at latency one makes the next cycle a ready cycle
  a_ready_latency_map: assert property (
    (outReady && latEff == 4'h1) ##1 (latEff == 4'h1) |-> readyCycle)
    else $error("ready cycle missing after ready at latency one");

  // Ready at latency three shows three cycles on
  a_ready_latency_three: assert property (
    (outReady && latEff == 4'h3) ##1 (latEff == 4'h3) [*3] |-> readyCycle)
    else $error("ready cycle missing after ready at latency three");

  // No beat taken while valid is low
  a_take_needs_valid: assert property (
    !inValid |-> !take)
    else $error("beat taken without valid");

  // With backpressure on, no beat outside a ready cycle
  a_take_ready_cycle: assert property (
    (st_reg.ctrlBp && !readyCycle) |-> !take)
    else $error("beat taken outside a ready cycle");

  // End beats bump the packet count by one
  a_pkt_count_step: assert property (
    (take && inBeat.eop && !clearCounts) |=>
      st_reg.pktCount == $past(st_reg.pktCount) + 32'h0000_0001)
    else $error("packet count did not step on an end beat");

  // A start marker with valid low leaves packet state untouched
  a_sop_ignored: assert property (
    (!inValid && inBeat.sop) |=> st_reg.phase == $past(st_reg.phase))
    else $error("start marker acted while valid was low");

  // Single-beat packet length is symbols per beat less empty
  a_single_len: assert property (
    (take && inBeat.sop && inBeat.eop) |=>
      st_reg.lastLen == `SHP_LEN_W'(`SHP_SYMBOLS) -
      `SHP_LEN_W'($past(inBeat.empty)))
    else $error("single beat length wrong");

  // Clean beats leave the error count unchanged
  a_err_count_step: assert property (
    (take && inBeat.error == `SHP_ERROR_W'(0) && !clearCounts) |=>
      $stable(st_reg.errCount))
    else $error("clean beat counted as faulty");

  // Bus answers one cycle after a request is seen
  a_bus_answer: assert property (
    ((read || write) && waitrequest) |=> !waitrequest)
    else $error("bus answer later than one cycle");

  // After reset the sink starts idle with a clear packet count
  a_reset_quiet: assert property (
    $rose(rst_n) |-> (st_reg.phase == SHP_IDLE &&
                      st_reg.pktCount == 32'h0000_0000))
    else $error("state not cleared by reset");

  // ============================================================
  // Further checks on counting, markers, data, ready timing and the control register

  // A faulty beat adds exactly one to the error count
  a_err_count_bump: assert property (
    (take && inBeat.error != `SHP_ERROR_W'(0) && !clearCounts) |=>
      st_reg.errCount == $past(st_reg.errCount) + 32'h0000_0001)
    else $error("faulty beat not counted");

  // A clear with no beat taken leaves both counters at zero
  a_clear_counts: assert property (
    (clearCounts && !take) |=>
      (st_reg.pktCount == 32'h0000_0000 &&
       st_reg.errCount == 32'h0000_0000))
    else $error("counters not cleared");

  // End marker with valid low must not count a packet
  a_eop_ignored: assert property (
    (!inValid && inBeat.eop && !clearCounts) |=> $stable(st_reg.pktCount))
    else $error("end marker acted while valid was low");

  // Empty is ignored on a beat without the end marker
  a_empty_ignored: assert property (
    (take && !inBeat.sop && !inBeat.eop) |=>
      st_reg.curLen == $past(st_reg.curLen) + `SHP_LEN_W'(`SHP_SYMBOLS))
    else $error("empty count used on a middle beat");

  // A start beat restarts the length at one full beat
  a_sop_restart: assert property (
    (take && inBeat.sop && !inBeat.eop) |=>
      st_reg.curLen == `SHP_LEN_W'(`SHP_SYMBOLS))
    else $error("start beat did not restart the length");

  // A start beat without an end opens a packet
  a_sop_enters: assert property (
    (take && inBeat.sop && !inBeat.eop) |=> st_reg.phase == SHP_IN_PACKET)
    else $error("start beat did not open a packet");

  // Any end beat closes the packet so the next one may abut
  a_eop_leaves: assert property (
    (take && inBeat.eop) |=> st_reg.phase == SHP_IDLE)
    else $error("end beat left the packet open");

  // Non-final beats are kept whole, symbol order unchanged
  a_symbol_order: assert property (
    (take && !inBeat.eop) |=> st_reg.lastData == $past(inBeat.data))
    else $error("beat data reordered");

  // Three empty symbols leave only the top symbol of the beat
  a_empty_zeroed: assert property (
    (take && inBeat.eop && inBeat.empty == 2'h3) |=>
      (st_reg.lastData[23:0] == 24'h00_0000 &&
       st_reg.lastData[31:24] == $past(inBeat.data[31:24])))
    else $error("empty symbols not at the low end");

  // Without backpressure every valid beat is taken
  a_nobp_take: assert property (
    (inValid && !st_reg.ctrlBp) |-> take)
    else $error("valid beat dropped without backpressure");

  // At zero latency ready and valid together make a transfer
  a_lat_zero_take: assert property (
    (inValid && outReady && latEff == 4'h0) |-> take)
    else $error("beat not taken with ready and valid");

  // The channel of each taken beat is kept as sent
  a_channel_kept: assert property (
    take |=> st_reg.lastChannel == $past(inBeat.channel))
    else $error("channel number not kept");

  // Ready at latency two shows two cycles on
  a_ready_latency_two: assert property (
    (outReady && latEff == 4'h2) ##1 (latEff == 4'h2) [*2] |-> readyCycle)
    else $error("ready cycle missing after ready at latency two");

  // Ready at the top latency of eight shows eight cycles on
  a_ready_latency_eight: assert property (
    (outReady && latEff == 4'h8) ##1 (latEff == 4'h8) [*8] |-> readyCycle)
    else $error("ready cycle missing after ready at latency eight");

  // Ready low at latency one leaves the next cycle not ready
  a_ready_low_one: assert property (
    (!outReady && latEff == 4'h1) ##1 (latEff == 4'h1) |-> !readyCycle)
    else $error("ready cycle without ready at latency one");

  // A control write sets ready and backpressure mode as written
  a_ctrl_write: assert property (
    (busWrite && address[4:2] == 3'(`SHP_OFS_CTRL >> 2) &&
     byteenable[0]) |=>
      (st_reg.ctrlReady == $past(writedata[`SHP_CTRL_READY_BIT]) &&
       st_reg.ctrlBp == $past(writedata[`SHP_CTRL_BP_BIT])))
    else $error("control write not applied");

endmodule

// [dv/shp_source_model.sv]
// Stream source model facing the packet sink's stream side.
// Assumes the bench pushes beats and mirrors the sink's mode inputs.
`timescale 1ns/1ps
`include "shp_cfg.svh"
module shp_source_model
  import shp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic outReady,
  input wire logic bpMode,
  input wire logic [3:0] latency,
  output logic inValid,
  output shp_beat_type inBeat
);
  shp_beat_type pending[$];
  logic [7:0] readyAgo;
  logic readyNext;

  function automatic void push(input shp_beat_type b);
    pending.push_back(b);
  endfunction

  // ============================================================
  // Whether the cycle after this edge is a ready cycle
  always_comb begin
    if (latency <= 4'h1) begin
      readyNext = outReady;
    end else begin
      readyNext = readyAgo[latency - 4'h2];
    end
  end

  // ============================================================
  // Outputs straight from flops junk while idle
  always @(posedge clk) begin
    if (!rst_n) begin
      inValid <= 1'b0;
      inBeat <= '0;
      readyAgo <= 8'h00;
    end else begin
      readyAgo <= {readyAgo[6:0], outReady};
      if (bpMode && latency == 4'h0 && inValid && !outReady) begin
        inValid <= 1'b1; // Hold until taken
      end else if (pending.size() > 0 &&
                   (!bpMode || latency == 4'h0 || readyNext)) begin
        inValid <= 1'b1;
        inBeat <= pending.pop_front();
      end else begin
        inValid <= 1'b0;
        // Markers and data flip, so a sink that looks at them errs
        inBeat <= ~inBeat;
      end
    end
  end
endmodule

// [dv/shp_sink_tb_top.sv]
// Self-checking bench for the stream packet sink.
// Assumes the source model in dv/ and the sink's register map.
`timescale 1ns/1ps
`include "shp_cfg.svh"
module shp_sink_tb_top;
  import shp_pkg::*;
  logic clk;
  logic rst_n;
  logic [`SHP_ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic inValid;
  shp_beat_type inBeat;
  logic outReady;
  logic bpMode;
  logic [3:0] latency;
  logic [3:0] lats[4] = '{4'h1, 4'h2, 4'h5, 4'h8};
  int num_errors;
  int compares;
  int pkts;

  shp_sink i_dut (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .inValid(inValid), .inBeat(inBeat),
    .outReady(outReady));
  shp_source_model i_src (.clk(clk), .rst_n(rst_n), .outReady(outReady),
    .bpMode(bpMode), .latency(latency), .inValid(inValid),
    .inBeat(inBeat));

  // ============================================================
  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ============================================================
  // One register access; held until waitrequest is seen low
  task automatic access(input logic wr, input logic [4:0] a,
                        input logic [31:0] wd, output logic [31:0] got);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      chk("waitrequest", 32'h0, {31'h0, waitrequest});
      conclude();
    end
    // Answer taken and request dropped at the edge that saw it low
    got = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic expect_reg(input string what, input logic [4:0] a,
                            input logic [31:0] exp);
    logic [31:0] got;
    access(1'b0, a, 32'h0, got);
    chk(what, exp, got);
  endtask

  // Writes control and tells the source model the same mode
  task automatic mode(input logic rdy, input logic bp, input logic [3:0] l);
    logic [31:0] unused;
    access(1'b1, `SHP_OFS_CTRL, {24'h0, l, 2'b00, bp, rdy}, unused);
    bpMode <= bp;
    latency <= l;
  endtask

  task automatic send(input logic [31:0] d, input logic [7:0] ch,
                      input logic [1:0] er, input logic s, input logic e,
                      input logic [1:0] em);
    i_src.push('{d, ch, er, s, e, em});
  endtask

  // Waits for the queue to empty; results show a cycle later
  task automatic drain();
    int n;
    n = 0;
    while ((i_src.pending.size() > 0 || inValid) && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) begin
      chk("drain", 32'h0, 32'h1);
      conclude();
    end
    repeat (2) @(posedge clk);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hF;
    bpMode = 1'b1;
    latency = 4'h0;
    num_errors = 0;
    compares = 0;
    pkts = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    expect_reg("ctrl", `SHP_OFS_CTRL, 32'h3);
    expect_reg("status", `SHP_OFS_STATUS, 32'h2);
    expect_reg("pkts", `SHP_OFS_PKT_COUNT, 32'h0);
    expect_reg("unmapped", 5'h1C, 32'h0);
    // Zero latency: beat waits while ready is low
    mode(1'b0, 1'b1, 4'h0);
    send(32'h11223344, 8'h05, 2'h0, 1'b1, 1'b0, 2'h0);
    send(32'hAABBCCDD, 8'h05, 2'h0, 1'b0, 1'b1, 2'h3);
    repeat (6) @(posedge clk);
    expect_reg("held", `SHP_OFS_STATUS, 32'h0);
    mode(1'b1, 1'b1, 4'h0);
    drain();
    expect_reg("pkts", `SHP_OFS_PKT_COUNT, 32'h1);
    expect_reg("len", `SHP_OFS_LAST_LEN, 32'd5);
    expect_reg("data", `SHP_OFS_LAST_DATA, 32'hAA000000);
    expect_reg("info", `SHP_OFS_LAST_INFO, 32'h005);
    // Abutting single-beat packets, one with an error flag
    send(32'h55667788, 8'h07, 2'h1, 1'b1, 1'b1, 2'h0);
    send(32'h01020304, 8'h09, 2'h0, 1'b1, 1'b1, 2'h1);
    drain();
    expect_reg("pkts", `SHP_OFS_PKT_COUNT, 32'h3);
    expect_reg("errs", `SHP_OFS_ERR_COUNT, 32'h1);
    expect_reg("len", `SHP_OFS_LAST_LEN, 32'd3);
    expect_reg("data", `SHP_OFS_LAST_DATA, 32'h01020300);
    expect_reg("info", `SHP_OFS_LAST_INFO, 32'h009);
    // Latencies 1, 2, 5 and 8: nothing moves until ready, then a whole packet
    pkts = 3;
    foreach (lats[i]) begin
      mode(1'b0, 1'b1, lats[i]);
      // Ready cycles granted before the drop must run out first
      repeat (10) @(posedge clk);
      send(32'h10203040, 8'h02, 2'h0, 1'b1, 1'b0, 2'h1);
      send(32'h50607080, 8'h02, 2'h0, 1'b0, 1'b0, 2'h3);
      send(32'h90A0B0C0, 8'h02, 2'h0, 1'b0, 1'b1, 2'h2);
      repeat (12) @(posedge clk);
      expect_reg("idle", `SHP_OFS_PKT_COUNT, pkts);
      mode(1'b1, 1'b1, lats[i]);
      drain();
      pkts++;
      expect_reg("lat pkts", `SHP_OFS_PKT_COUNT, pkts);
      expect_reg("lat len", `SHP_OFS_LAST_LEN, 32'd10);
      expect_reg("lat ctrl", `SHP_OFS_CTRL, {lats[i], 4'h3});
    end
    // No backpressure: beats are taken with ready low
    mode(1'b0, 1'b0, 4'h0);
    // Control lands on the answering edge; look one edge later
    @(posedge clk);
    chk("ready pin", 32'h0, {31'h0, outReady});
    send(32'hCAFEF00D, 8'hFF, 2'h0, 1'b1, 1'b1, 2'h0);
    drain();
    expect_reg("nobp pkts", `SHP_OFS_PKT_COUNT, pkts + 1);
    expect_reg("nobp info", `SHP_OFS_LAST_INFO, 32'h0FF);
    // Clear both counters
    mode(1'b1, 1'b1, 4'h0);
    writedata <= 32'h0;
    begin
      logic [31:0] unused;
      access(1'b1, `SHP_OFS_CTRL, 32'h103, unused);
    end
    expect_reg("clr pkts", `SHP_OFS_PKT_COUNT, 32'h0);
    expect_reg("clr errs", `SHP_OFS_ERR_COUNT, 32'h0);
    expect_reg("clr ctrl", `SHP_OFS_CTRL, 32'h3);
    conclude();
  end
endmodule
